// ===== src/hls_pkg.sv
// How it works
// R1: with function enabled, a detected alarm sends an alarm indication to the controller.
// R2: controller answers any alarm indication by broadcasting forced stop to every amplifier.
// R3: forced stop without own fault latches warning, shows E7.1, decelerates to standstill.
// R4: function active after reset; config lowest digit equal 1 disables it.
// R5: warning stays latched until the controller sends an error reset command.
// R6: supply loss during forced-stop deceleration switches stopping to the dynamic brake.
// R7: upstream power loss makes this axis decelerate, go not-connected and show AA.
// R8: own input power removed stops motor by dynamic brake and blanks the display.
// R9: link loss forces deceleration stop, or dynamic brake for the severe kind.
// R10: disabled function sends no alarm indication; own alarm stops only own motor.
package hls_pkg;
   localparam logic [3:0] HLS_CFG_DISABLE   = 4'h1;
   localparam logic [3:0] HLS_CFG_RESET     = 4'h0;
   // display codes
   localparam logic [1:0] HLS_DISP_NONE     = 2'h0;
   localparam logic [1:0] HLS_DISP_E71      = 2'h1;
   localparam logic [1:0] HLS_DISP_AA       = 2'h2;
   localparam logic [1:0] HLS_DISP_BLANK    = 2'h3;
   typedef enum logic [1:0] {
      HLS_RUN   = 2'b00,
      HLS_DECEL = 2'b01,
      HLS_DB    = 2'b10
   } hls_stop_t;
endpackage : hls_pkg

// ===== src/hls_sequencer.sv
module hls_sequencer
   import hls_pkg::*;
(
   input  wire logic       ref_clk_in,
   input  wire logic       rst_b_in,
   input  wire logic [3:0] cfg_digit_in,
   input  wire logic       own_alarm_in,
   input  wire logic       alarm_db_in,
   input  wire logic       forced_stop_in,
   input  wire logic       error_reset_in,
   input  wire logic       supply_lost_in,
   input  wire logic       upstream_lost_in,
   input  wire logic       link_lost_in,
   input  wire logic       link_lost_hard_in,
   output logic            alarm_ind_out,
   output logic            warn_out,
   output logic [1:0]      disp_out,
   output logic            decel_out,
   output logic            dyn_brake_out,
   output logic            not_conn_out
);
   // the whole register image of the sequencer
   typedef struct packed {
      logic [7:0] s1;        // first sync stage, read only by the second
      logic [7:0] s2;        // second sync stage, the only copy logic reads
      logic       alarm_ind;
      logic       warn;
      logic [1:0] disp;
      logic       not_conn;
      logic       decel;
      logic       dyn_brake;
      hls_stop_t  stop;
   } hls_state_t;

   hls_state_t st;
   hls_state_t next_st;
   logic [7:0] raw;
   logic       en;
   logic       fault;
   logic       al;
   logic       db;
   logic       fs;
   logic       er;
   logic       sl;
   logic       ul;
   logic       ll;
   logic       llh;
   logic       next_warn;
   logic       next_nc;
   logic       brake_req;
   logic       decel_req;
   logic       release_ok;

   // display priority: blank over no connection over the warning code
   function automatic logic [1:0] hls_disp_sel(input logic blank,
                                               input logic no_conn,
                                               input logic warn);
      logic [1:0] code;
      if (blank) begin
         code = HLS_DISP_BLANK; // [R8]
      end else if (no_conn) begin
         code = HLS_DISP_AA; // [R7]
      end else if (warn) begin
         code = HLS_DISP_E71; // [R3]
      end else begin
         code = HLS_DISP_NONE;
      end
      return code;
   endfunction : hls_disp_sel

   // stop machine: the brake always wins, leaving it needs an error reset
   function automatic hls_stop_t hls_next_stop(input hls_stop_t cur,
                                               input logic      brake,
                                               input logic      slow,
                                               input logic      clear);
      hls_stop_t res;
      res = cur;
      case (cur)
         HLS_RUN,
         HLS_DECEL: begin
            if (brake) begin
               res = HLS_DB;
            end else if (slow) begin
               res = HLS_DECEL;
            end else begin
               res = HLS_RUN;
            end
         end
         HLS_DB: begin
            // a deceleration cause still present after the reset keeps the axis slowing down
            if (!brake && clear) begin
               res = slow ? HLS_DECEL : HLS_RUN;
            end
         end
         default: begin
            res = HLS_DB;
         end
      endcase
      return res;
   endfunction : hls_next_stop

   // all pin levels but the config digit pass the two sync stages before any decision reads them
   assign raw = {link_lost_hard_in, link_lost_in, upstream_lost_in, supply_lost_in,
                 error_reset_in, forced_stop_in, alarm_db_in, own_alarm_in};
   assign {llh, ll, ul, sl, er, fs, db, al} = st.s2;

   // the config digit comes from logic on this clock, so it is read directly
   assign en         = (cfg_digit_in != HLS_CFG_DISABLE); // [R4]
   assign fault      = al | db;

   // set wins over the clear for both latched conditions
   assign next_warn  = (fs & ~fault) | (st.warn & ~er); // [R3] [R5]
   assign next_nc    = ul | (st.not_conn & ~er); // [R7]

   assign brake_req  = sl | db | llh; // [R6] [R8] [R9]
   assign decel_req  = al | ul | ll | next_warn | next_nc; // [R3] [R7] [R9] [R10]
   assign release_ok = er & ~fault; // [R5]

   always_comb begin
      next_st           = st;
      next_st.s1        = raw;
      next_st.s2        = st.s1;
      next_st.alarm_ind = fault & en; // [R1] [R10]
      next_st.warn      = next_warn;
      next_st.not_conn  = next_nc;
      next_st.stop      = hls_next_stop(st.stop, brake_req, decel_req, release_ok);
      next_st.decel     = (next_st.stop == HLS_DECEL);
      next_st.dyn_brake = (next_st.stop == HLS_DB);
      next_st.disp      = hls_disp_sel(sl, next_nc, next_warn);
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign alarm_ind_out = st.alarm_ind;
   assign warn_out      = st.warn;
   assign disp_out      = st.disp;
   assign decel_out     = st.decel;
   assign dyn_brake_out = st.dyn_brake;
   assign not_conn_out  = st.not_conn;

   // alarm indication towards the controller
   property p_alarm;
      @(posedge ref_clk_in) disable iff (!rst_b_in) $rose(al) && en |=> alarm_ind_out;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm not sent"); // [R1]

   property p_cfg;
      @(posedge ref_clk_in) disable iff (!rst_b_in) $rose(al) && cfg_digit_in == HLS_CFG_RESET |=> alarm_ind_out;
   endproperty
   a_cfg: assert property (p_cfg) else $error("default config not enabled"); // [R4]

   property p_noind;
      @(posedge ref_clk_in) disable iff (!rst_b_in) !fault |=> !alarm_ind_out;
   endproperty
   a_noind: assert property (p_noind) else $error("indication without alarm"); // [R1]

   property p_dis;
      @(posedge ref_clk_in) disable iff (!rst_b_in) !en && $stable(cfg_digit_in) |=> !alarm_ind_out;
   endproperty
   a_dis: assert property (p_dis) else $error("alarm sent while disabled"); // [R10]

   // forced-stop warning
   property p_warn;
      @(posedge ref_clk_in) disable iff (!rst_b_in) fs && !fault |=> warn_out;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not raised"); // [R3]

   property p_refuse;
      @(posedge ref_clk_in) disable iff (!rst_b_in) fault && !warn_out |=> !warn_out;
   endproperty
   a_refuse: assert property (p_refuse) else $error("warning raised during own fault"); // [R3]

   property p_hold;
      @(posedge ref_clk_in) disable iff (!rst_b_in) warn_out && !er |=> warn_out;
   endproperty
   a_hold: assert property (p_hold) else $error("warning dropped"); // [R5]

   property p_clr;
      @(posedge ref_clk_in) disable iff (!rst_b_in) er && !fs |=> !warn_out;
   endproperty
   a_clr: assert property (p_clr) else $error("warning not cleared by error reset"); // [R5]

   property p_e71;
      @(posedge ref_clk_in) disable iff (!rst_b_in)
         warn_out && !not_conn_out && disp_out != HLS_DISP_BLANK |-> disp_out == HLS_DISP_E71;
   endproperty
   a_e71: assert property (p_e71) else $error("warning code not shown"); // [R3]

   // braking and deceleration
   property p_db;
      @(posedge ref_clk_in) disable iff (!rst_b_in) sl |=> dyn_brake_out && disp_out == HLS_DISP_BLANK;
   endproperty
   a_db: assert property (p_db) else $error("no brake on supply loss"); // [R6] [R8]

   property p_dbhold;
      @(posedge ref_clk_in) disable iff (!rst_b_in) dyn_brake_out && !er |=> dyn_brake_out;
   endproperty
   a_dbhold: assert property (p_dbhold) else $error("brake left without error reset"); // [R6]

   property p_aa;
      @(posedge ref_clk_in) disable iff (!rst_b_in) ul && !sl |=> not_conn_out && disp_out == HLS_DISP_AA;
   endproperty
   a_aa: assert property (p_aa) else $error("no AA on upstream loss"); // [R7]

   property p_upstop;
      @(posedge ref_clk_in) disable iff (!rst_b_in) ul && !brake_req && !dyn_brake_out |=> decel_out;
   endproperty
   a_upstop: assert property (p_upstop) else $error("no deceleration on upstream loss"); // [R7]

   property p_dec;
      @(posedge ref_clk_in) disable iff (!rst_b_in) al && !brake_req && !dyn_brake_out |=> decel_out;
   endproperty
   a_dec: assert property (p_dec) else $error("own alarm does not stop own motor"); // [R10]

   property p_link;
      @(posedge ref_clk_in) disable iff (!rst_b_in) ll |=> decel_out || dyn_brake_out;
   endproperty
   a_link: assert property (p_link) else $error("no stop on link loss"); // [R9]

   property p_hard;
      @(posedge ref_clk_in) disable iff (!rst_b_in) llh |=> dyn_brake_out;
   endproperty
   a_hard: assert property (p_hard) else $error("no brake on severe link loss"); // [R9]

   // main scenarios
   c_ind: cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) $rose(alarm_ind_out));
   c_fs:  cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) warn_out ##1 !warn_out);
   c_db:  cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) decel_out ##1 dyn_brake_out);
   c_aa:  cover property (@(posedge ref_clk_in) disable iff (!rst_b_in) not_conn_out);
endmodule : hls_sequencer

// ===== tb/hls_host_model.sv
module hls_host_model
   import hls_pkg::*;
(
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   input  wire logic alarm_ind_in,
   input  wire logic stop_req_in,
   input  wire logic clear_req_in,
   output logic      forced_stop_out,
   output logic      error_reset_out
);
   timeunit 1ns;
   timeprecision 100ps;
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         forced_stop_out <= 1'b0;
         error_reset_out <= 1'b0;
      end else begin
         forced_stop_out <= alarm_ind_in | stop_req_in;
         error_reset_out <= clear_req_in;
      end
   end
endmodule : hls_host_model

// ===== tb/test_hot_line_forced_stop_sequencer.sv
module test_hot_line_forced_stop_sequencer
   import hls_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst_b = 0, sreq = 0, creq = 0, wm = 0, fs, er, ind, warn, dec, db, nc;
   logic [3:0] cfg = 4'h0;
   logic [5:0] iv = 6'h00;
   logic [1:0] disp;
   int n_fail = 0, tests_run = 0, seed = 32'h495CA793, r;
   initial forever #12.5 clk = ~clk;
   hls_sequencer dut (.ref_clk_in(clk), .rst_b_in(rst_b), .cfg_digit_in(cfg), .own_alarm_in(iv[5]),
      .alarm_db_in(iv[4]), .forced_stop_in(fs), .error_reset_in(er), .supply_lost_in(iv[3]),
      .upstream_lost_in(iv[2]), .link_lost_in(iv[1]), .link_lost_hard_in(iv[0]), .alarm_ind_out(ind),
      .warn_out(warn), .disp_out(disp), .decel_out(dec), .dyn_brake_out(db), .not_conn_out(nc));
   hls_host_model host (.ref_clk_in(clk), .rst_b_in(rst_b), .alarm_ind_in(ind), .stop_req_in(sreq),
      .clear_req_in(creq), .forced_stop_out(fs), .error_reset_out(er));
   task stop_test();
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   task chk(input logic [1:0] got, input logic [1:0] exp, input logic on);
      if (on) begin
         tests_run++;
         if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %b expected %b", $time, got, exp);
         end
      end
   endtask : chk
   // v: alarm, db alarm, supply, upstream, link, hard link, stop request, clear request
   task go(input logic [7:0] v, input logic [5:0] m, input logic [2:0] e);
      logic en;
      logic f;
      @(posedge clk);
      iv <= v[7:2];
      sreq <= v[1];
      creq <= v[0];
      repeat (8) @(posedge clk);
      #1;
      en = (cfg != HLS_CFG_DISABLE) && (v[7] || v[6]);
      f = en || v[1];
      if (f && !(v[7] || v[6])) wm = 1'b1;
      else if (v[0] && !f) wm = 1'b0;
      chk({1'b0, ind}, {1'b0, en}, m[5]);
      chk({1'b0, warn}, {1'b0, wm}, m[4]);
      chk(disp, v[5] ? HLS_DISP_BLANK : v[4] ? HLS_DISP_AA : wm ? HLS_DISP_E71 : HLS_DISP_NONE, m[3]);
      chk({1'b0, dec}, {1'b0, e[2]}, m[2]);
      chk({1'b0, db}, {1'b0, e[1]}, m[1]);
      chk({1'b0, nc}, {1'b0, e[0]}, m[0]);
   endtask : go
   initial begin
      r = $random(seed);
      cfg = (r[3:0] == HLS_CFG_DISABLE) ? HLS_CFG_RESET : r[3:0];
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      go(8'h80, 6'h30, 3'h0);
      go(8'h00, 6'h00, 3'h0);
      go(8'h01, 6'h38, 3'h0);
      @(posedge clk) cfg <= HLS_CFG_DISABLE;
      go(8'h80, 6'h20, 3'h0);
      go(8'h00, 6'h20, 3'h0);
      @(posedge clk) cfg <= HLS_CFG_RESET;
      go(8'h40, 6'h20, 3'h0);
      go(8'h00, 6'h00, 3'h0);
      go(8'h01, 6'h38, 3'h0);
      go(8'h02, 6'h3C, 3'h4);
      go(8'h00, 6'h18, 3'h0);
      go(8'h01, 6'h38, 3'h0);
      go(8'h02, 6'h14, 3'h4);
      go(8'h22, 6'h0A, 3'h2);
      go(8'h01, 6'h1A, 3'h0);
      go(8'h10, 6'h0F, 3'h5);
      go(8'h01, 6'h09, 3'h0);
      go(8'h08, 6'h04, 3'h4);
      go(8'h01, 6'h00, 3'h0);
      go(8'h04, 6'h02, 3'h2);
      stop_test();
   end
endmodule : test_hot_line_forced_stop_sequencer
